// *** rtl/eqc_pkg.sv ***
// Constants and state type for the equalizer setting control block.
// Assumes three-level strap pins are sensed by pad logic into a 2-bit level.
//
// Overview of operation
// - Select pin high selects short-channel optimisation.
// - Select pin low or open selects long-channel.
// - Strap mode: boost code from boost strap.
// - Serial mode: sixteen boost codes, per channel.
// - Strap mode: gain code from gain strap.
// - Serial mode: gain per channel, independent.
// - Strap mode: swing code from swing strap.
// - Serial mode: swing per channel, independent.
// - Enable high powers down all output stages.
// - Enable open powers up all channels.
// - Enable low holds reset, refuses writes.
// - Serial mode loads power state from enable only on leaving reset.
// - One programming block holds all channel controls.

package eqc_pkg;

	// ==========================================================
	// Sizes and channel-loss figures
	// ==========================================================
	// Number of equalizer channels.
	localparam int NCH = 4;
	// Upper loss bound of the short case, in dB.
	localparam int SHORT_MAX_LOSS_DB = 18;
	// Upper loss bound of the long case, in dB.
	localparam int LONG_MAX_LOSS_DB = 33;

	// ==========================================================
	// Three-level pin encoding
	// ==========================================================
	// Pad sense codes; 2'h3 is treated like open.
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_OPEN = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// ==========================================================
	// Strap decode values
	// ==========================================================
	// Boost codes, long case.
	localparam logic [3:0] BOOST_LONG_HI = 4'hE;
	localparam logic [3:0] BOOST_LONG_OP = 4'h9;
	localparam logic [3:0] BOOST_LONG_LO = 4'h5;
	// Boost codes, short case.
	localparam logic [3:0] BOOST_SHRT_HI = 4'h9;
	localparam logic [3:0] BOOST_SHRT_OP = 4'h5;
	localparam logic [3:0] BOOST_SHRT_LO = 4'h3;
	// Gain codes, long case.
	localparam logic [1:0] GAIN_LONG_HI = 2'h3;
	localparam logic [1:0] GAIN_LONG_OP = 2'h2;
	localparam logic [1:0] GAIN_LONG_LO = 2'h1;
	// Gain codes, short case.
	localparam logic [1:0] GAIN_SHRT_HI = 2'h2;
	localparam logic [1:0] GAIN_SHRT_OP = 2'h1;
	localparam logic [1:0] GAIN_SHRT_LO = 2'h0;
	// Swing codes, same for both cases.
	localparam logic [1:0] SWING_HI = 2'h3;
	localparam logic [1:0] SWING_OP = 2'h2;
	localparam logic [1:0] SWING_LO = 2'h1;

	// ==========================================================
	// Register defaults after any reset
	// ==========================================================
	localparam logic [3:0] BOOST_DEF = 4'h9;
	localparam logic [1:0] GAIN_DEF  = 2'h2;
	localparam logic [1:0] SWING_DEF = 2'h2;
	// Output stages stay off while in reset.
	localparam logic [3:0] PD_DEF    = 4'hF;

	// ==========================================================
	// Write field select bits
	// ==========================================================
	localparam int SEL_BOOST = 0;
	localparam int SEL_GAIN  = 1;
	localparam int SEL_SWING = 2;
	localparam int SEL_PD    = 3;

	// ==========================================================
	// State
	// ==========================================================
	// Startup phase: sample mode, hold in reset, run.
	typedef enum logic [1:0] {
		EQC_PH_POR,
		EQC_PH_HOLD,
		EQC_PH_RUN
	} eqc_phase_t;

	// Whole programming block of the device.
	typedef struct packed {
		eqc_phase_t       ph;
		logic             serial;
		logic             short_opt;
		logic [3:0][3:0]  boost;
		logic [3:0][1:0]  gain;
		logic [3:0][1:0]  swing;
		logic [3:0]       pd;
	} eqc_state_t;

	// Value taken on power-on reset.
	localparam eqc_state_t RST_STATE = '{
		ph:        EQC_PH_POR,
		serial:    1'b0,
		short_opt: 1'b0,
		boost:     {4{BOOST_DEF}},
		gain:      {4{GAIN_DEF}},
		swing:     {4{SWING_DEF}},
		pd:        PD_DEF
	};

endpackage

// *** rtl/eqc_top.sv ***
// Equalizer setting control: straps or per-channel writes to channel codes.
// Assumes all inputs are synchronous to clk_sys_i; rst_i is power-on reset.
`timescale 1ns/100ps
`default_nettype none

module eqc_top (
	// Clock and power-on reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Board straps
	input  wire logic        serial_mode_i,
	input  wire logic [1:0]  chan_len_lvl_i,
	input  wire logic [1:0]  boost_level_strap_i,
	input  wire logic [1:0]  gain_strap_i,
	input  wire logic [1:0]  swing_strap_i,
	input  wire logic [1:0]  enable_lvl_i,
	// Per-channel write port from the serial bus
	input  wire logic        wr_valid_i,
	output logic             wr_ready_o,
	input  wire logic [1:0]  wr_chan_i,
	input  wire logic [3:0]  wr_sel_i,
	input  wire logic [3:0]  wr_boost_i,
	input  wire logic [1:0]  wr_gain_i,
	input  wire logic [1:0]  wr_swing_i,
	input  wire logic        wr_pd_i,
	// Channel settings to the analog stages
	output logic [15:0]      boost_code_o,
	output logic [7:0]       wideband_gain_code_o,
	output logic [7:0]       swing_code_o,
	output logic [3:0]       out_pd_o,
	output logic             short_opt_o,
	// Status
	output logic             serial_mode_o,
	output logic             in_reset_o
);

	// ==========================================================
	// Strap decode helpers
	// ==========================================================
	// Level code 2'h3 falls to the open branch, so an odd pad reading stays harmless.
	// Boost code for a strap level and channel case.
	function automatic logic [3:0] f_boost(
		input logic [1:0] lvl,
		input logic       shrt
	);
		logic [3:0] r;
		r = shrt ? eqc_pkg::BOOST_SHRT_OP : eqc_pkg::BOOST_LONG_OP;
		if (lvl == eqc_pkg::LVL_HIGH) begin
			r = shrt ? eqc_pkg::BOOST_SHRT_HI : eqc_pkg::BOOST_LONG_HI;
		end else if (lvl == eqc_pkg::LVL_LOW) begin
			r = shrt ? eqc_pkg::BOOST_SHRT_LO : eqc_pkg::BOOST_LONG_LO;
		end
		return r;
	endfunction

	// Gain code for a strap level and channel case.
	function automatic logic [1:0] f_gain(
		input logic [1:0] lvl,
		input logic       shrt
	);
		logic [1:0] r;
		r = shrt ? eqc_pkg::GAIN_SHRT_OP : eqc_pkg::GAIN_LONG_OP;
		if (lvl == eqc_pkg::LVL_HIGH) begin
			r = shrt ? eqc_pkg::GAIN_SHRT_HI : eqc_pkg::GAIN_LONG_HI;
		end else if (lvl == eqc_pkg::LVL_LOW) begin
			r = shrt ? eqc_pkg::GAIN_SHRT_LO : eqc_pkg::GAIN_LONG_LO;
		end
		return r;
	endfunction

	// Swing code; the channel case plays no part here.
	function automatic logic [1:0] f_swing(input logic [1:0] lvl);
		logic [1:0] r;
		r = eqc_pkg::SWING_OP;
		if (lvl == eqc_pkg::LVL_HIGH) begin
			r = eqc_pkg::SWING_HI;
		end else if (lvl == eqc_pkg::LVL_LOW) begin
			r = eqc_pkg::SWING_LO;
		end
		return r;
	endfunction

	// ==========================================================
	// State and decoded pin levels
	// ==========================================================
	eqc_pkg::eqc_state_t  st_q;      // Registered programming block.
	eqc_pkg::eqc_state_t  st_d;      // Next value.
	logic                 en_low;    // Enable pin holds reset.
	logic                 en_high;   // Enable pin asks for power-down.
	logic                 len_short; // Select pin asks for short case.
	logic                 wr_acc;    // A write is taken this cycle.
	logic [3:0]           exp_boost; // Strap decode of boost.
	logic [1:0]           exp_gain;  // Strap decode of gain.
	logic [1:0]           exp_swing; // Strap decode of swing.

	// Pin levels; an open select pin reads as long.
	assign en_low    = (enable_lvl_i == eqc_pkg::LVL_LOW);
	assign en_high   = (enable_lvl_i == eqc_pkg::LVL_HIGH);
	assign len_short = (chan_len_lvl_i == eqc_pkg::LVL_HIGH);
	assign exp_boost = f_boost(boost_level_strap_i, len_short);
	assign exp_gain  = f_gain(gain_strap_i, len_short);
	assign exp_swing = f_swing(swing_strap_i);

	// Ready is combinational, so a write that meets enable falling is refused in that cycle.
	// refuse writes in reset
	assign wr_ready_o = st_q.serial && (st_q.ph == eqc_pkg::EQC_PH_RUN)
		&& !en_low;
	assign wr_acc = wr_valid_i && wr_ready_o;

	// ==========================================================
	// Next-state logic
	// ==========================================================
	// All channel controls live in one block; straps or writes feed it.
	always_comb begin
		st_d = st_q;
		case (st_q.ph)
			// Mode select is sampled once, right after power-on reset.
			eqc_pkg::EQC_PH_POR: begin
				st_d.serial = serial_mode_i;
				st_d.ph     = eqc_pkg::EQC_PH_HOLD;
			end
			// Held at defaults until the enable pin leaves low.
			// Writes cannot land here, as ready stays low until RUN.
			eqc_pkg::EQC_PH_HOLD: begin
				if (!en_low) begin
					st_d.pd = {4{en_high}};
					st_d.ph = eqc_pkg::EQC_PH_RUN;
				end
			end
			eqc_pkg::EQC_PH_RUN: begin
				if (en_low) begin
					st_d       = eqc_pkg::RST_STATE;
					st_d.serial = st_q.serial;
					st_d.ph     = eqc_pkg::EQC_PH_HOLD;
				end else begin
					st_d.short_opt = len_short;
					if (!st_q.serial) begin
						st_d.boost = {4{exp_boost}};
						st_d.gain  = {4{exp_gain}};
						st_d.swing = {4{exp_swing}};
						st_d.pd    = {4{en_high}};
					end else if (wr_acc) begin
						if (wr_sel_i[eqc_pkg::SEL_BOOST]) begin
							st_d.boost[wr_chan_i] = wr_boost_i;
						end
						if (wr_sel_i[eqc_pkg::SEL_GAIN]) begin
							st_d.gain[wr_chan_i] = wr_gain_i;
						end
						if (wr_sel_i[eqc_pkg::SEL_SWING]) begin
							st_d.swing[wr_chan_i] = wr_swing_i;
						end
						// Output enable is part of the same block.
						if (wr_sel_i[eqc_pkg::SEL_PD]) begin
							st_d.pd[wr_chan_i] = wr_pd_i;
						end
					end
				end
			end
			// Unused encoding recovers through the sampling phase.
			default: begin
				st_d = eqc_pkg::RST_STATE;
			end
		endcase
		// Power-on reset overrides everything.
		if (rst_i) begin
			st_d = eqc_pkg::RST_STATE;
		end
	end

	// ==========================================================
	// State register
	// ==========================================================
	// Reset is folded into st_d, so this stays a plain flop bank.
	// Every pin is taken as synchronous to clk_sys_i, so no synchroniser sits in front.
	always_ff @(posedge clk_sys_i) begin
		st_q <= st_d;
	end

	// ==========================================================
	// Outputs other than wr_ready_o, all from flops, in_reset_o by a decode of the phase
	// ==========================================================
	assign boost_code_o         = st_q.boost;
	assign wideband_gain_code_o = st_q.gain;
	assign swing_code_o         = st_q.swing;
	assign out_pd_o             = st_q.pd;
	assign short_opt_o          = st_q.short_opt;
	assign serial_mode_o        = st_q.serial;
	// Status decodes the registered phase only, so it never follows a pin directly.
	assign in_reset_o           = (st_q.ph != eqc_pkg::EQC_PH_RUN);

	// ==========================================================
	// Assertions and cover points
	// ==========================================================
	// Properties are checked only outside power-on reset; each names its rule.
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// Helper terms shared by several properties below.
	logic strap_run; // Running in strap mode with enable not low.
	logic ser_run;   // Running in serial mode with enable not low.
	assign strap_run = (st_q.ph == eqc_pkg::EQC_PH_RUN) && !st_q.serial
		&& !en_low;
	assign ser_run = (st_q.ph == eqc_pkg::EQC_PH_RUN) && st_q.serial
		&& !en_low;

	AST_SHORT_OPT: assert property (
		(st_q.ph == eqc_pkg::EQC_PH_RUN) && !en_low && len_short
		|=> short_opt_o)
		else $error("Short case not selected with select pin high.");

	AST_LONG_OPT: assert property (
		(st_q.ph == eqc_pkg::EQC_PH_RUN) && !en_low && !len_short
		|=> !short_opt_o)
		else $error("Long case not selected with select pin low or open.");

	AST_BOOST_STRAP: assert property (
		strap_run |=> boost_code_o == {4{$past(exp_boost)}})
		else $error("Boost codes do not follow the boost strap.");

	AST_BOOST_WR: assert property (
		wr_acc && wr_sel_i[eqc_pkg::SEL_BOOST]
		|=> st_q.boost[$past(wr_chan_i)] == $past(wr_boost_i))
		else $error("Boost write not stored in its channel.");

	AST_GAIN_STRAP: assert property (
		strap_run |=> wideband_gain_code_o == {4{$past(exp_gain)}})
		else $error("Gain codes do not follow the gain strap.");

	AST_GAIN_ISOL: assert property (
		wr_acc && (wr_chan_i == 2'h0) |=> $stable(st_q.gain[3:1]))
		else $error("Gain write to channel 0 disturbed other channels.");

	AST_SWING_STRAP: assert property (
		strap_run |=> swing_code_o == {4{$past(exp_swing)}})
		else $error("Swing codes do not follow the swing strap.");

	AST_SWING_ISOL: assert property (
		wr_acc && (wr_chan_i == 2'h3) |=> $stable(st_q.swing[2:0]))
		else $error("Swing write to channel 3 disturbed other channels.");

	AST_PD_HIGH: assert property (
		strap_run && en_high |=> out_pd_o == 4'hF)
		else $error("Enable high did not power down all channels.");

	AST_PD_OPEN: assert property (
		strap_run && !en_high ##1 !en_low |-> out_pd_o == 4'h0)
		else $error("Enable open did not power up all channels.");

	AST_RESET_HOLD: assert property (
		en_low && (st_q.ph != eqc_pkg::EQC_PH_POR)
		|-> !wr_ready_o ##1 (in_reset_o
		&& boost_code_o == {4{eqc_pkg::BOOST_DEF}}))
		else $error("Enable low did not hold reset with defaults.");

	AST_SER_PD_KEEP: assert property (
		ser_run && !(wr_acc && wr_sel_i[eqc_pkg::SEL_PD])
		|=> $stable(out_pd_o))
		else $error("Serial mode power state changed without a write.");

	AST_HOLD_PD_LOAD: assert property (
		(st_q.ph == eqc_pkg::EQC_PH_HOLD) && !en_low
		|=> !in_reset_o && (out_pd_o == {4{$past(en_high)}}))
		else $error("Leaving reset did not load the power state from the enable pin.");

	AST_GAIN_WR: assert property (
		wr_acc && wr_sel_i[eqc_pkg::SEL_GAIN]
		|=> st_q.gain[$past(wr_chan_i)] == $past(wr_gain_i))
		else $error("Gain write not stored in its channel.");

	AST_SWING_WR: assert property (
		wr_acc && wr_sel_i[eqc_pkg::SEL_SWING]
		|=> st_q.swing[$past(wr_chan_i)] == $past(wr_swing_i))
		else $error("Swing write not stored in its channel.");

	// Straps must not reach the codes once the bus owns the block.
	AST_SER_STRAP_IGNORED: assert property (
		ser_run && !wr_acc
		|=> $stable(boost_code_o) && $stable(wideband_gain_code_o) && $stable(swing_code_o))
		else $error("Channel codes changed in serial mode without a write.");

	// Cover points: strap run, back-to-back writes, leaving reset, serial start powered down, refusal.
	COV_STRAP_RUN: cover property (strap_run ##1 strap_run);
	COV_SER_WRITE: cover property (wr_acc ##1 wr_acc);
	COV_RESET_EXIT: cover property (
		en_low ##1 !en_low ##1 !in_reset_o);
	COV_SER_PD_START: cover property (
		(st_q.ph == eqc_pkg::EQC_PH_HOLD) && st_q.serial && en_high);
	// A request held off while the block is not ready to take it.
	COV_WR_REFUSED: cover property (wr_valid_i && !wr_ready_o);

endmodule

`default_nettype wire

// *** verification/eqc_bus_model.sv ***
// Serial bus master stand-in that drives the per-channel write port.
// Assumes each task is entered just after a rising edge of clk_sys_i.
`timescale 1ns/100ps
`default_nettype none

module eqc_bus_model (
	// Clock and handshake
	input  wire logic       clk_sys_i,
	input  wire logic       wr_ready_i,
	// Write request
	output logic            wr_valid_o,
	output logic [1:0]      wr_chan_o,
	output logic [3:0]      wr_sel_o,
	output logic [3:0]      wr_boost_o,
	output logic [1:0]      wr_gain_o,
	output logic [1:0]      wr_swing_o,
	output logic            wr_pd_o
);
	// ==========================================================
	// Request driver
	// ==========================================================
	// The port starts idle.
	initial begin
		wr_valid_o = 1'b0;
		{wr_chan_o, wr_sel_o, wr_boost_o, wr_gain_o, wr_swing_o, wr_pd_o} = 15'h0000;
	end

	// Valid stays high at the end so back-to-back writes never toggle it twice in one step.
	// A refused request is given up after eight edges.
	task automatic write(input logic [1:0] ch, input logic [3:0] sel, input logic [3:0] b,
		input logic [1:0] g, input logic [1:0] s, input logic p, output logic taken);
		int n;
		n = 0;
		wr_valid_o = 1'b1;
		{wr_chan_o, wr_sel_o, wr_boost_o, wr_gain_o, wr_swing_o, wr_pd_o} = {ch, sel, b, g, s, p};
		// Ready is read 1 ns after an edge, once settled, and says whether the next edge takes the request.
		taken = (wr_ready_i === 1'b1);
		while (!taken && n < 8) begin
			@(posedge clk_sys_i);
			#1;
			taken = (wr_ready_i === 1'b1);
			n++;
		end
		// The taking edge passes with the request still standing.
		if (taken) begin
			@(posedge clk_sys_i);
			#1;
		end
	endtask

	// Released data is inverted so a stale value is never mistaken for a fresh one.
	task automatic idle();
		wr_valid_o = 1'b0;
		{wr_chan_o, wr_sel_o, wr_boost_o, wr_gain_o, wr_swing_o, wr_pd_o} =
			~{wr_chan_o, wr_sel_o, wr_boost_o, wr_gain_o, wr_swing_o, wr_pd_o};
	endtask
endmodule
`default_nettype wire

// *** verification/eqc_top_tb.sv ***
// Self-checking bench for the equalizer setting control block.
// Assumes the bus model is compiled first; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module eqc_top_tb;
	// ==========================================================
	// Signals and expected tables
	// ==========================================================
	logic        clk_sys_i           = 1'b0;
	logic        rst_i               = 1'b1;
	logic        serial_mode_i       = 1'b0;
	logic [1:0]  chan_len_lvl_i      = 2'h0;
	logic [1:0]  boost_level_strap_i = 2'h1;
	logic [1:0]  gain_strap_i        = 2'h1;
	logic [1:0]  swing_strap_i       = 2'h1;
	logic [1:0]  enable_lvl_i        = 2'h1;
	logic        wr_valid_i, wr_ready_o, wr_pd_i, short_opt_o, serial_mode_o, in_reset_o;
	logic [1:0]  wr_chan_i, wr_gain_i, wr_swing_i;
	logic [3:0]  wr_sel_i, wr_boost_i, out_pd_o;
	logic [15:0] boost_code_o;
	logic [7:0]  wideband_gain_code_o, swing_code_o;
	int          n_fail              = 0;
	int          n_compared          = 0;
	// Boost codes for strap low, open, high; long and short cases.
	localparam logic [3:0] BL [3] = '{4'h5, 4'h9, 4'hE};
	localparam logic [3:0] BS [3] = '{4'h3, 4'h5, 4'h9};
	// Written boost values include both ends of the sixteen settings.
	localparam logic [3:0] BW [4] = '{4'h0, 4'h7, 4'hA, 4'hF};

	always #5 clk_sys_i = ~clk_sys_i;

	eqc_top u_eqc_top (.clk_sys_i, .rst_i, .serial_mode_i, .chan_len_lvl_i, .boost_level_strap_i,
		.gain_strap_i, .swing_strap_i, .enable_lvl_i, .wr_valid_i, .wr_ready_o, .wr_chan_i, .wr_sel_i,
		.wr_boost_i, .wr_gain_i, .wr_swing_i, .wr_pd_i, .boost_code_o, .wideband_gain_code_o,
		.swing_code_o, .out_pd_o, .short_opt_o, .serial_mode_o, .in_reset_o);

	eqc_bus_model u_eqc_bus_model (.clk_sys_i(clk_sys_i), .wr_ready_i(wr_ready_o),
		.wr_valid_o(wr_valid_i), .wr_chan_o(wr_chan_i), .wr_sel_o(wr_sel_i), .wr_boost_o(wr_boost_i),
		.wr_gain_o(wr_gain_i), .wr_swing_o(wr_swing_i), .wr_pd_o(wr_pd_i));

	// ==========================================================
	// Helpers
	// ==========================================================
	// Inputs always move 1 ns after an edge, clear of the sampling point.
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// The mode strap is settled before reset ends; RUN is reached two edges after release.
	task automatic do_reset(input logic mode, input logic [1:0] en);
		rst_i = 1'b1;
		serial_mode_i = mode;
		enable_lvl_i = en;
		step(6);
		rst_i = 1'b0;
		step(3);
		chk("in_reset", in_reset_o, 1'b0);
	endtask

	task automatic en_set(input logic [1:0] v);
		enable_lvl_i = v;
		step(2);
	endtask

	task automatic report_and_stop();
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		int s;
		int l;
		logic tk;
		do_reset(1'b0, 2'h1);
		// Every strap level in both channel cases; swing runs opposite to catch swapped straps.
		for (s = 0; s < 3; s++) begin
			for (l = 0; l < 3; l++) begin
				chan_len_lvl_i = s[1:0];
				boost_level_strap_i = l[1:0];
				gain_strap_i = l[1:0];
				swing_strap_i = 2'(2 - l);
				step(2);
				chk("short", short_opt_o, s == 2);
				chk("boost", boost_code_o, {4{(s == 2) ? BS[l] : BL[l]}});
				chk("gain", wideband_gain_code_o, {4{2'(l + (s != 2))}});
				chk("swing", swing_code_o, {4{2'(3 - l)}});
			end
		end
		$display("test strap done");
		en_set(2'h2);
		chk("pd", out_pd_o, 4'hF);
		en_set(2'h1);
		chk("pd", out_pd_o, 4'h0);
		u_eqc_bus_model.write(2'h0, 4'hF, 4'h0, 2'h0, 2'h0, 1'b0, tk);
		u_eqc_bus_model.idle();
		chk("taken", tk, 1'b0);
		en_set(2'h0);
		chk("in_reset", in_reset_o, 1'b1);
		chk("swing", swing_code_o, 8'hAA);
		chk("pd", out_pd_o, 4'hF);
		$display("test enable done");
		do_reset(1'b1, 2'h2);
		chk("pd", out_pd_o, 4'hF);
		chk("mode", serial_mode_o, 1'b1);
		// Four back-to-back writes, one per channel.
		for (l = 0; l < 4; l++) begin
			u_eqc_bus_model.write(l[1:0], 4'hF, BW[l], l[1:0], 2'(3 - l), l[0], tk);
			chk("taken", tk, 1'b1);
		end
		u_eqc_bus_model.idle();
		step(1);
		chk("boost", boost_code_o, 16'hFA70);
		chk("gain", wideband_gain_code_o, 8'hE4);
		chk("swing", swing_code_o, 8'h1B);
		chk("pd", out_pd_o, 4'hA);
		// Only the gain field of channel 1 is selected.
		u_eqc_bus_model.write(2'h1, 4'h2, 4'h3, 2'h0, 2'h3, 1'b1, tk);
		u_eqc_bus_model.idle();
		step(1);
		chk("gain", wideband_gain_code_o, 8'hE0);
		chk("boost", boost_code_o, 16'hFA70);
		chk("swing", swing_code_o, 8'h1B);
		chk("pd", out_pd_o, 4'hA);
		chan_len_lvl_i = 2'h2;
		boost_level_strap_i = 2'h0;
		en_set(2'h1);
		chk("pd", out_pd_o, 4'hA);
		chk("boost", boost_code_o, 16'hFA70);
		chk("short", short_opt_o, 1'b1);
		en_set(2'h0);
		chk("ready", wr_ready_o, 1'b0);
		chk("boost", boost_code_o, 16'h9999);
		chk("pd", out_pd_o, 4'hF);
		u_eqc_bus_model.write(2'h2, 4'hF, 4'h1, 2'h1, 2'h1, 1'b0, tk);
		u_eqc_bus_model.idle();
		chk("taken", tk, 1'b0);
		en_set(2'h1);
		chk("pd", out_pd_o, 4'h0);
		chk("boost", boost_code_o, 16'h9999);
		$display("test serial done");
		report_and_stop();
	end

	// The tests need about 70 cycles; 10,000 cycles means a hang.
	initial begin
		#100000;
		n_fail++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
`default_nettype wire
